// ---- hdl/amx_pkg.sv ----
// Constants, field positions and helpers for the max-address command block
package amx_pkg;

   // ****************************************
   // Task-file offsets
   // ****************************************
   localparam logic [9:0] OFS_FEAT_ERR = 10'h1F1;
   localparam logic [9:0] OFS_COUNT = 10'h1F2;
   localparam logic [9:0] OFS_ADDR_LOW = 10'h1F3;
   localparam logic [9:0] OFS_ADDR_MIDL = 10'h1F4;
   localparam logic [9:0] OFS_ADDR_MIDH = 10'h1F5;
   localparam logic [9:0] OFS_DRV_TOP = 10'h1F6;
   localparam logic [9:0] OFS_CMD_STAT = 10'h1F7;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned STAT_BSY = 7;
   localparam int unsigned STAT_DRDY = 6;
   localparam int unsigned STAT_DWF = 5;
   localparam int unsigned STAT_ERR = 0;
   localparam int unsigned EBIT_ICRC = 7;
   localparam int unsigned EBIT_UNC = 6;
   localparam int unsigned EBIT_IDNF = 4;
   localparam int unsigned EBIT_ABRT = 2;
   localparam int unsigned EBIT_TK0NF = 1;
   localparam int unsigned DRV_LBA = 6;
   localparam int unsigned CNT_PERSIST = 0;
   localparam int unsigned ADDR_W = 28;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [7:0] TF_RESET = 8'h00;
   localparam logic [7:0] DIAG_PASS = 8'h01;

   localparam logic [7:0] OP_SET_MAX = 8'hF9;
   localparam logic [7:0] OP_NATIVE_MAX = 8'hF8;
   localparam logic [7:0] OP_DIAG = 8'h90;
   localparam logic [7:0] OP_RECAL = 8'h10;
   localparam logic [7:0] OP_READ = 8'h20;
   localparam logic [7:0] OP_READ_LONG = 8'h22;
   localparam logic [7:0] OP_WRITE = 8'h30;
   localparam logic [7:0] OP_WRITE_LONG = 8'h32;
   localparam logic [7:0] OP_WRITE_VFY = 8'h3C;
   localparam logic [7:0] OP_READ_VFY = 8'h40;
   localparam logic [7:0] OP_FORMAT = 8'h50;
   localparam logic [7:0] OP_SEEK = 8'h70;
   localparam logic [7:0] OP_SMART = 8'hB0;
   localparam logic [7:0] OP_READ_MUL = 8'hC4;
   localparam logic [7:0] OP_WRITE_MUL = 8'hC5;
   localparam logic [7:0] OP_READ_DMA = 8'hC8;
   localparam logic [7:0] OP_WRITE_DMA = 8'hCA;
   localparam logic [7:0] OP_FLUSH = 8'hE7;

   typedef enum logic [1:0] {S_INIT, S_IDLE, S_EXEC} amx_state_t;

   // Error register bits that a command may report
   function automatic logic [7:0] amx_allowed(input logic [7:0] op);
      logic [7:0] m;
      m = 8'h00;
      m[EBIT_ABRT] = 1'b1;
      case (op)
         OP_READ_DMA, OP_WRITE_DMA: m[EBIT_ICRC] = 1'b1;
         default: m[EBIT_ICRC] = 1'b0;
      endcase
      case (op)
         OP_READ, OP_READ_MUL, OP_READ_DMA, OP_WRITE_VFY, OP_READ_VFY: m[EBIT_UNC] = 1'b1;
         default: m[EBIT_UNC] = 1'b0;
      endcase
      case (op)
         OP_READ, OP_WRITE, OP_READ_MUL, OP_WRITE_MUL, OP_READ_DMA, OP_WRITE_DMA, OP_WRITE_VFY,
         OP_READ_VFY, OP_SEEK, OP_FORMAT, OP_READ_LONG, OP_WRITE_LONG, OP_SMART, OP_FLUSH,
         OP_SET_MAX: m[EBIT_IDNF] = 1'b1;
         default: m[EBIT_IDNF] = 1'b0;
      endcase
      m[EBIT_TK0NF] = (op == OP_RECAL);
      return m;
   endfunction : amx_allowed

   // Ordering key: block address as is, or cylinder, head, sector
   function automatic logic [27:0] amx_key(input logic lba, input logic [27:0] a);
      return lba ? a : {a[23:8], a[27:24], a[7:0]};
   endfunction : amx_key

endpackage : amx_pkg

// ---- hdl/amx_max_address.sv ----
// Max-address command handling and error posting of the disk device
//
// Function
// - Opcode F9 sets busy, latches the max address, clears busy, interrupts.
// - An accepted maximum is what the identify data reports.
// - Media access beyond the current maximum is rejected with ID-not-found.
// - Persist flag set keeps the new maximum over power-on and hard reset.
// - Volatile maximum is dropped at reset; last persisted or default returns.
// - Only one persisted set per reset interval; further ones abort.
// - Opcode F8 loads the native maximum into the address registers.
// - Address bytes: drive/top byte, two middle bytes, low byte.
// - Completion shows the address, status and error registers.
// - Each command reports only its permitted error bits.
// - Native-max command never reports ID-not-found.
// - Diagnostic uses only the ERR status bit; error byte is its result code.
// - Reading status drops the interrupt request.
`timescale 1ns/1ns
module amx_max_address #(
   parameter logic [27:0] NATIVE_MAX = 28'hFFFFFFF
) (
   // Clock and resets
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic HARD_RESET_N,
   // Task-file access
   input wire logic [9:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic INTRQ,
   // Media address check
   input wire logic ACCESS_REQ,
   input wire logic ACCESS_LBA_MODE,
   input wire logic [27:0] ACCESS_ADDR,
   output logic ACCESS_DONE,
   output logic ACCESS_REJECT,
   // Error posting from other command engines
   input wire logic ERR_POST,
   input wire logic [7:0] ERR_CMD,
   input wire logic [7:0] ERR_BITS,
   input wire logic ERR_FAULT,
   // Identify data
   output logic [27:0] IDENT_MAX,
   output logic IDENT_LBA_MODE,
   // Non-volatile store of the persisted maximum
   input wire logic PERSIST_VALID,
   input wire logic [28:0] PERSIST_IN,
   output logic PERSIST_SAVE,
   output logic [28:0] PERSIST_DATA
);

   // ****************************************
   // Reset and pin synchronisers
   // ****************************************
   logic rst_m_q, rst_n;
   logic hr1_q, hr2_q, hr3_q, hrst_evt;

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         rst_m_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n <= rst_m_q;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         hr1_q <= 1'b1;
         hr2_q <= 1'b1;
         hr3_q <= 1'b1;
      end else begin
         hr1_q <= HARD_RESET_N;
         hr2_q <= hr1_q;
         hr3_q <= hr2_q;
      end
   end
   assign hrst_evt = hr3_q && !hr2_q;

   // ****************************************
   // Task-file state
   // ****************************************
   amx_pkg::amx_state_t state_q;
   logic [7:0] feat_q, count_q, alow_q, amidl_q, amidh_q, drv_q, err_q, op_q;
   logic bsy_q, drdy_q, dwf_q, errb_q;
   logic [28:0] limit_q, pers_q;
   logic once_q;
   logic [27:0] tf_addr;
   logic tf_lba, persist_req, set_abort, set_idnf, set_ok, acc_bad, is_idle;
   logic [7:0] post_mask, status;

   assign tf_addr = {drv_q[3:0], amidh_q, amidl_q, alow_q};
   assign tf_lba = drv_q[amx_pkg::DRV_LBA];
   assign persist_req = count_q[amx_pkg::CNT_PERSIST];
   assign is_idle = (state_q == amx_pkg::S_IDLE);
   assign set_abort = persist_req && once_q;
   // Ordering follows the task-file mode bit for both addresses in the set check, and each address's own mode bit for accesses
   assign set_idnf = !set_abort &&
                     (amx_pkg::amx_key(tf_lba, tf_addr) > amx_pkg::amx_key(tf_lba, NATIVE_MAX));
   assign set_ok = (state_q == amx_pkg::S_EXEC) && (op_q == amx_pkg::OP_SET_MAX) && !set_abort && !set_idnf;
   assign acc_bad = ACCESS_REQ &&
                    (amx_pkg::amx_key(ACCESS_LBA_MODE, ACCESS_ADDR) > amx_pkg::amx_key(limit_q[28], limit_q[27:0]));
   assign post_mask = ERR_BITS & amx_pkg::amx_allowed(ERR_CMD);
   assign status = {bsy_q, drdy_q, dwf_q, 4'h0, errb_q};

   // Host writes are dropped while busy; the host is expected to poll first
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= amx_pkg::S_INIT;
         {feat_q, count_q, alow_q, amidl_q, amidh_q, drv_q} <= {6{amx_pkg::TF_RESET}};
         err_q <= amx_pkg::TF_RESET;
         op_q <= amx_pkg::TF_RESET;
         {bsy_q, drdy_q, dwf_q, errb_q} <= 4'h0;
      end else if (hrst_evt) begin
         state_q <= amx_pkg::S_IDLE;
         {feat_q, count_q, alow_q, amidl_q, amidh_q, drv_q} <= {6{amx_pkg::TF_RESET}};
         err_q <= amx_pkg::TF_RESET;
         {bsy_q, dwf_q, errb_q} <= 3'h0;
         drdy_q <= 1'b1;
      end else begin
         case (state_q)
            amx_pkg::S_INIT: begin
               drdy_q <= 1'b1;
               state_q <= amx_pkg::S_IDLE;
            end
            amx_pkg::S_IDLE: begin
               if (REG_WR) begin
                  case (REG_ADDR)
                     amx_pkg::OFS_FEAT_ERR: feat_q <= REG_WDATA;
                     amx_pkg::OFS_COUNT: count_q <= REG_WDATA;
                     amx_pkg::OFS_ADDR_LOW: alow_q <= REG_WDATA;
                     amx_pkg::OFS_ADDR_MIDL: amidl_q <= REG_WDATA;
                     amx_pkg::OFS_ADDR_MIDH: amidh_q <= REG_WDATA;
                     amx_pkg::OFS_DRV_TOP: drv_q <= REG_WDATA;
                     amx_pkg::OFS_CMD_STAT: begin
                        // Parameters are taken as they stand now
                        op_q <= REG_WDATA;
                        bsy_q <= 1'b1;
                        {dwf_q, errb_q} <= 2'h0;
                        err_q <= 8'h00;
                        state_q <= amx_pkg::S_EXEC;
                     end
                     default: ;
                  endcase
               end else if (acc_bad) begin
                  err_q <= 8'h01 << amx_pkg::EBIT_IDNF;
                  errb_q <= 1'b1;
               end else if (ERR_POST) begin
                  if (ERR_CMD == amx_pkg::OP_DIAG) begin
                     err_q <= ERR_BITS;
                     errb_q <= (ERR_BITS != amx_pkg::DIAG_PASS);
                     dwf_q <= 1'b0;
                  end else begin
                     err_q <= post_mask;
                     errb_q <= (post_mask != 8'h00) || ERR_FAULT;
                     dwf_q <= ERR_FAULT;
                  end
               end
            end
            amx_pkg::S_EXEC: begin
               bsy_q <= 1'b0;
               state_q <= amx_pkg::S_IDLE;
               case (op_q)
                  amx_pkg::OP_SET_MAX: begin
                     if (set_abort) begin
                        err_q <= 8'h01 << amx_pkg::EBIT_ABRT;
                        errb_q <= 1'b1;
                     end else if (set_idnf) begin
                        err_q <= 8'h01 << amx_pkg::EBIT_IDNF;
                        errb_q <= 1'b1;
                     end
                  end
                  amx_pkg::OP_NATIVE_MAX: begin
                     // Only abort could apply here, never ID-not-found
                     drv_q <= {drv_q[7:4], NATIVE_MAX[27:24]};
                     amidh_q <= NATIVE_MAX[23:16];
                     amidl_q <= NATIVE_MAX[15:8];
                     alow_q <= NATIVE_MAX[7:0];
                  end
                  default: begin
                     err_q <= 8'h01 << amx_pkg::EBIT_ABRT;
                     errb_q <= 1'b1;
                  end
               endcase
            end
            default: state_q <= amx_pkg::S_IDLE;
         endcase
      end
   end

   // ****************************************
   // Address limit and persistence
   // ****************************************
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         limit_q <= {1'b1, NATIVE_MAX};
         pers_q <= {1'b1, NATIVE_MAX};
         once_q <= 1'b0;
         PERSIST_SAVE <= 1'b0;
         PERSIST_DATA <= {1'b1, NATIVE_MAX};
      end else begin
         PERSIST_SAVE <= 1'b0;
         if (state_q == amx_pkg::S_INIT) begin
            // Power-on: the store holds the last persisted maximum, if any
            limit_q <= PERSIST_VALID ? PERSIST_IN : {1'b1, NATIVE_MAX};
            pers_q <= PERSIST_VALID ? PERSIST_IN : {1'b1, NATIVE_MAX};
            once_q <= 1'b0;
         end else if (hrst_evt) begin
            limit_q <= pers_q;
            once_q <= 1'b0;
         end else if (set_ok) begin
            limit_q <= {tf_lba, tf_addr};
            if (persist_req) begin
               pers_q <= {tf_lba, tf_addr};
               once_q <= 1'b1;
               PERSIST_SAVE <= 1'b1;
               PERSIST_DATA <= {tf_lba, tf_addr};
            end
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         IDENT_MAX <= NATIVE_MAX;
         IDENT_LBA_MODE <= 1'b1;
      end else begin
         IDENT_MAX <= limit_q[27:0];
         IDENT_LBA_MODE <= limit_q[28];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         ACCESS_DONE <= 1'b0;
         ACCESS_REJECT <= 1'b0;
      end else begin
         ACCESS_DONE <= ACCESS_REQ;
         ACCESS_REJECT <= acc_bad;
      end
   end

   // A completion in the same cycle as a status read still raises the request
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         INTRQ <= 1'b0;
      end else if (hrst_evt) begin
         INTRQ <= 1'b0;
      end else begin
         INTRQ <= (state_q == amx_pkg::S_EXEC) || (is_idle && !REG_WR && !acc_bad && ERR_POST) ||
                  (INTRQ && !(REG_RD && REG_ADDR == amx_pkg::OFS_CMD_STAT));
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            amx_pkg::OFS_FEAT_ERR: REG_RDATA <= err_q;
            amx_pkg::OFS_COUNT: REG_RDATA <= count_q;
            amx_pkg::OFS_ADDR_LOW: REG_RDATA <= alow_q;
            amx_pkg::OFS_ADDR_MIDL: REG_RDATA <= amidl_q;
            amx_pkg::OFS_ADDR_MIDH: REG_RDATA <= amidh_q;
            amx_pkg::OFS_DRV_TOP: REG_RDATA <= drv_q;
            amx_pkg::OFS_CMD_STAT: REG_RDATA <= status;
            default: REG_RDATA <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!rst_n);

   sequence s_cmd(logic [7:0] op);
      is_idle && !hrst_evt && REG_WR && REG_ADDR == amx_pkg::OFS_CMD_STAT && REG_WDATA == op;
   endsequence
   sequence s_busy_then_done;
      bsy_q ##1 (!bsy_q && INTRQ);
   endsequence

   property p_set_max_flow;
      s_cmd(amx_pkg::OP_SET_MAX) ##1 !hrst_evt[*2] |-> $past(bsy_q) && !bsy_q && INTRQ;
   endproperty
   a_set_max_flow: assert property (p_set_max_flow) else $error("set max did not busy then interrupt");
   property p_native_flow;
      s_cmd(amx_pkg::OP_NATIVE_MAX) ##1 !hrst_evt |-> s_busy_then_done or (##1 hrst_evt);
   endproperty
   a_native_flow: assert property (p_native_flow) else $error("native max did not busy then interrupt");
   property p_ident;
      set_ok && !hrst_evt |-> ##2 IDENT_MAX == $past(tf_addr, 2);
   endproperty
   a_ident: assert property (p_ident) else $error("identify maximum not updated");
   property p_reject;
      ACCESS_REQ && amx_pkg::amx_key(ACCESS_LBA_MODE, ACCESS_ADDR) > amx_pkg::amx_key(limit_q[28], limit_q[27:0])
      |=> ACCESS_REJECT && ACCESS_DONE;
   endproperty
   a_reject: assert property (p_reject) else $error("out of range access not rejected");
   property p_second_persist;
      state_q == amx_pkg::S_EXEC && op_q == amx_pkg::OP_SET_MAX && once_q && persist_req && !hrst_evt
      |=> err_q[amx_pkg::EBIT_ABRT] && errb_q && $stable(limit_q);
   endproperty
   a_second_persist: assert property (p_second_persist) else $error("second persisted set not aborted");
   property p_persist_save;
      set_ok && persist_req && !hrst_evt |=> PERSIST_SAVE && PERSIST_DATA == limit_q && once_q;
   endproperty
   a_persist_save: assert property (p_persist_save) else $error("persisted maximum not saved");
   property p_hard_restore;
      hrst_evt && state_q != amx_pkg::S_INIT |=> limit_q == $past(pers_q) && !once_q;
   endproperty
   a_hard_restore: assert property (p_hard_restore) else $error("hard reset did not restore limit");
   property p_native_no_idnf;
      state_q == amx_pkg::S_EXEC && op_q == amx_pkg::OP_NATIVE_MAX && !hrst_evt
      |=> !err_q[amx_pkg::EBIT_IDNF] && alow_q == NATIVE_MAX[7:0];
   endproperty
   a_native_no_idnf: assert property (p_native_no_idnf) else $error("native max reported ID not found");
   property p_status_read;
      REG_RD && REG_ADDR == amx_pkg::OFS_CMD_STAT && state_q != amx_pkg::S_EXEC && !ERR_POST |=> !INTRQ;
   endproperty
   a_status_read: assert property (p_status_read) else $error("interrupt held after status read");
   property p_unknown_op;
      state_q == amx_pkg::S_EXEC && op_q != amx_pkg::OP_SET_MAX && op_q != amx_pkg::OP_NATIVE_MAX && !hrst_evt
      |=> err_q == (8'h01 << amx_pkg::EBIT_ABRT) && errb_q && !bsy_q;
   endproperty
   a_unknown_op: assert property (p_unknown_op) else $error("unknown opcode not aborted");
   property p_post_mask;
      is_idle && ERR_POST && !REG_WR && !acc_bad && !hrst_evt && ERR_CMD != amx_pkg::OP_DIAG
      |=> (err_q & ~amx_pkg::amx_allowed($past(ERR_CMD))) == 8'h00;
   endproperty
   a_post_mask: assert property (p_post_mask) else $error("forbidden error bit posted");

endmodule : amx_max_address

// ---- verification/amx_host_model.sv ----
// Host adapter and non-volatile limit store facing the max-address block
`timescale 1ns/1ns
module amx_host_model (
   // Clock
   input wire logic CLOCK,
   // Task-file access
   output logic [9:0] REG_ADDR,
   output logic REG_WR,
   output logic REG_RD,
   output logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   // Non-volatile store
   input wire logic PERSIST_SAVE,
   input wire logic [28:0] PERSIST_DATA,
   output logic PERSIST_VALID,
   output logic [28:0] PERSIST_IN
);
   initial begin
      REG_ADDR = 10'h000;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_WDATA = 8'h00;
      PERSIST_VALID = 1'b0;
      PERSIST_IN = 29'h0000000;
   end

   // ****************************************
   // Store: no reset term, it must outlive both resets
   // ****************************************
   always @(posedge CLOCK) begin
      if (PERSIST_SAVE === 1'b1) begin
         PERSIST_VALID <= 1'b1;
         PERSIST_IN <= PERSIST_DATA;
      end
   end

   // ****************************************
   // Bus cycles
   // ****************************************
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLOCK);
      REG_WR <= 1'b0;
      // Released data bus must not keep looking valid
      REG_WDATA <= ~d;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge CLOCK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLOCK);
      REG_RD <= 1'b0;
      @(negedge CLOCK);
      d = REG_RDATA;
   endtask : rd

   task automatic wait_idle(output logic [7:0] st);
      int n;
      n = 0;
      rd(amx_pkg::OFS_CMD_STAT, st);
      while (st[amx_pkg::STAT_BSY] !== 1'b0 && n < 8) begin
         rd(amx_pkg::OFS_CMD_STAT, st);
         n++;
      end
   endtask : wait_idle

   task automatic issue(input logic [7:0] op, input logic lba, input logic [27:0] a, input logic [7:0] sc);
      logic [7:0] st;
      wait_idle(st);
      wr(amx_pkg::OFS_DRV_TOP, {1'b1, lba, 2'b10, a[27:24]});
      wr(amx_pkg::OFS_ADDR_MIDH, a[23:16]);
      wr(amx_pkg::OFS_ADDR_MIDL, a[15:8]);
      wr(amx_pkg::OFS_ADDR_LOW, a[7:0]);
      wr(amx_pkg::OFS_COUNT, sc);
      wr(amx_pkg::OFS_CMD_STAT, op);
   endtask : issue
endmodule : amx_host_model

// ---- verification/tb_top.sv ----
// Self-checking testbench of the max-address command block
`timescale 1ns/1ns
module tb_top;
   localparam logic [27:0] NATIVE = 28'h9876543;
   typedef struct packed {logic [7:0] op; logic [7:0] bits; logic fault; logic [7:0] er; logic [7:0] st;} amx_post_t;
   // Allowed masks worked out by hand from the per-command error table
   localparam amx_post_t POSTS [10] = '{
      '{8'hC8, 8'hFF, 1'b0, 8'hD4, 8'h41}, '{8'hCA, 8'hFF, 1'b0, 8'h94, 8'h41},
      '{8'h20, 8'hFF, 1'b0, 8'h54, 8'h41}, '{8'h30, 8'hFF, 1'b0, 8'h14, 8'h41},
      '{8'h10, 8'hFF, 1'b0, 8'h06, 8'h41}, '{8'hF8, 8'hFF, 1'b0, 8'h04, 8'h41},
      '{8'hEE, 8'hFF, 1'b0, 8'h04, 8'h41}, '{8'h30, 8'h00, 1'b1, 8'h00, 8'h61},
      '{8'h90, 8'h01, 1'b1, 8'h01, 8'h40}, '{8'h90, 8'h03, 1'b0, 8'h03, 8'h41}};
   logic CLOCK, NRST, HARD_RESET_N, REG_WR, REG_RD, INTRQ;
   logic [9:0] REG_ADDR;
   logic [7:0] REG_WDATA, REG_RDATA, ERR_CMD, ERR_BITS;
   logic ACCESS_REQ, ACCESS_LBA_MODE, ACCESS_DONE, ACCESS_REJECT, ERR_POST, ERR_FAULT;
   logic [27:0] ACCESS_ADDR, IDENT_MAX;
   logic IDENT_LBA_MODE, PERSIST_VALID, PERSIST_SAVE;
   logic [28:0] PERSIST_IN, PERSIST_DATA;
   logic [7:0] d;
   int err_total, tests_run, cycles;

   amx_max_address #(.NATIVE_MAX(NATIVE)) u_amx_max_address (.CLOCK(CLOCK), .NRST(NRST),
      .HARD_RESET_N(HARD_RESET_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .INTRQ(INTRQ), .ACCESS_REQ(ACCESS_REQ),
      .ACCESS_LBA_MODE(ACCESS_LBA_MODE), .ACCESS_ADDR(ACCESS_ADDR), .ACCESS_DONE(ACCESS_DONE),
      .ACCESS_REJECT(ACCESS_REJECT), .ERR_POST(ERR_POST), .ERR_CMD(ERR_CMD), .ERR_BITS(ERR_BITS),
      .ERR_FAULT(ERR_FAULT), .IDENT_MAX(IDENT_MAX), .IDENT_LBA_MODE(IDENT_LBA_MODE),
      .PERSIST_VALID(PERSIST_VALID), .PERSIST_IN(PERSIST_IN), .PERSIST_SAVE(PERSIST_SAVE),
      .PERSIST_DATA(PERSIST_DATA));
   amx_host_model u_amx_host_model (.CLOCK(CLOCK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PERSIST_SAVE(PERSIST_SAVE),
      .PERSIST_DATA(PERSIST_DATA), .PERSIST_VALID(PERSIST_VALID), .PERSIST_IN(PERSIST_IN));

   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end

   // ****************************************
   // Comparisons and closing
   // ****************************************
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t register byte %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   task automatic cmp_addr(input logic [27:0] got, input logic [27:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t address %h expected %h", $time, got, exp);
      end
   endtask : cmp_addr

   task automatic cmp_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // Generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ****************************************
   // Sequences
   // ****************************************
   task automatic check_done(input logic [7:0] st, input logic [7:0] er);
      logic [7:0] v;
      repeat (3) @(posedge CLOCK);
      @(negedge CLOCK);
      cmp_bit(INTRQ, 1'b1);
      u_amx_host_model.wait_idle(v);
      cmp_byte(v, st);
      cmp_bit(INTRQ, 1'b0);
      u_amx_host_model.rd(amx_pkg::OFS_FEAT_ERR, v);
      cmp_byte(v, er);
   endtask : check_done

   task automatic access(input logic [27:0] a, input logic rej);
      @(posedge CLOCK);
      ACCESS_REQ <= 1'b1;
      ACCESS_ADDR <= a;
      @(posedge CLOCK);
      ACCESS_REQ <= 1'b0;
      ACCESS_ADDR <= ~a;
      @(negedge CLOCK);
      cmp_bit(ACCESS_DONE, 1'b1);
      cmp_bit(ACCESS_REJECT, rej);
   endtask : access

   initial begin
      NRST = 1'b0;
      HARD_RESET_N = 1'b1;
      ACCESS_REQ = 1'b0;
      ACCESS_LBA_MODE = 1'b1;
      ACCESS_ADDR = 28'h0000000;
      ERR_POST = 1'b0;
      ERR_CMD = 8'h00;
      ERR_BITS = 8'h00;
      ERR_FAULT = 1'b0;
      err_total = 0;
      tests_run = 0;
      cycles = 0;
      repeat (3) @(posedge CLOCK);
      NRST <= 1'b1;
      repeat (6) @(posedge CLOCK);
      @(negedge CLOCK);
      cmp_addr(IDENT_MAX, NATIVE);
      cmp_bit(IDENT_LBA_MODE, 1'b1);
      u_amx_host_model.rd(10'h1F8, d);
      cmp_byte(d, 8'h00);
      u_amx_host_model.issue(amx_pkg::OP_NATIVE_MAX, 1'b1, 28'h0000000, 8'h00);
      check_done(8'h40, 8'h00);
      u_amx_host_model.rd(amx_pkg::OFS_DRV_TOP, d);
      cmp_byte(d & 8'h0F, 8'h09);
      u_amx_host_model.rd(amx_pkg::OFS_ADDR_MIDH, d);
      cmp_byte(d, 8'h87);
      u_amx_host_model.rd(amx_pkg::OFS_ADDR_MIDL, d);
      cmp_byte(d, 8'h65);
      u_amx_host_model.rd(amx_pkg::OFS_ADDR_LOW, d);
      cmp_byte(d, 8'h43);
      u_amx_host_model.issue(amx_pkg::OP_SET_MAX, 1'b1, 28'h0001000, 8'h00);
      check_done(8'h40, 8'h00);
      cmp_addr(IDENT_MAX, 28'h0001000);
      access(28'h0001000, 1'b0);
      access(28'h0001001, 1'b1);
      u_amx_host_model.rd(amx_pkg::OFS_FEAT_ERR, d);
      cmp_byte(d, 8'h10);
      u_amx_host_model.rd(amx_pkg::OFS_CMD_STAT, d);
      cmp_byte(d, 8'h41);
      u_amx_host_model.issue(amx_pkg::OP_SET_MAX, 1'b1, 28'hFFFFFFF, 8'h00);
      check_done(8'h41, 8'h10);
      cmp_addr(IDENT_MAX, 28'h0001000);
      u_amx_host_model.issue(amx_pkg::OP_SET_MAX, 1'b1, 28'h0000800, 8'h01);
      check_done(8'h40, 8'h00);
      cmp_addr(PERSIST_IN[27:0], 28'h0000800);
      u_amx_host_model.issue(amx_pkg::OP_SET_MAX, 1'b1, 28'h0000700, 8'h01);
      check_done(8'h41, 8'h04);
      cmp_addr(IDENT_MAX, 28'h0000800);
      u_amx_host_model.issue(amx_pkg::OP_SET_MAX, 1'b0, 28'h0000900, 8'h00);
      check_done(8'h40, 8'h00);
      cmp_bit(IDENT_LBA_MODE, 1'b0);
      cmp_addr(IDENT_MAX, 28'h0000900);
      // Cylinder-ordered check: a larger raw value can still lie inside the limit
      @(posedge CLOCK);
      ACCESS_LBA_MODE <= 1'b0;
      access(28'h1000800, 1'b0);
      access(28'h0000A00, 1'b1);
      @(posedge CLOCK);
      ACCESS_LBA_MODE <= 1'b1;
      @(posedge CLOCK);
      HARD_RESET_N <= 1'b0;
      repeat (3) @(posedge CLOCK);
      HARD_RESET_N <= 1'b1;
      repeat (6) @(posedge CLOCK);
      @(negedge CLOCK);
      cmp_addr(IDENT_MAX, 28'h0000800);
      cmp_bit(IDENT_LBA_MODE, 1'b1);
      u_amx_host_model.issue(amx_pkg::OP_SET_MAX, 1'b1, 28'h0000A00, 8'h01);
      check_done(8'h40, 8'h00);
      @(posedge CLOCK);
      NRST <= 1'b0;
      @(negedge CLOCK);
      cmp_addr(IDENT_MAX, NATIVE);
      repeat (2) @(posedge CLOCK);
      NRST <= 1'b1;
      repeat (6) @(posedge CLOCK);
      @(negedge CLOCK);
      cmp_addr(IDENT_MAX, 28'h0000A00);
      u_amx_host_model.issue(8'hEE, 1'b1, 28'h0000000, 8'h00);
      check_done(8'h41, 8'h04);
      for (int i = 0; i < 10; i++) begin
         @(posedge CLOCK);
         ERR_POST <= 1'b1;
         ERR_CMD <= POSTS[i].op;
         ERR_BITS <= POSTS[i].bits;
         ERR_FAULT <= POSTS[i].fault;
         @(posedge CLOCK);
         ERR_POST <= 1'b0;
         check_done(POSTS[i].st, POSTS[i].er);
      end
      tally_and_finish();
   end
endmodule : tb_top
